// [verilog/pm_clock_mode_ctrl.sv]
`timescale 1ns/1ps
// How it works
// - each sleep picks its mode from the idle and source bits at that instant
// - run and idle share a source; a differing source on sleep forces a switch
// - watchdog time-out wakes from idle, resets when running
// - idle wake resumes running on current source, then returns to primary when ready
// - wake sequences never modify the idle or source select bits
// - internal idle stops core clock, peripherals stay clocked from internal mux
// - idle set plus upper source bit gives internal idle; lower bit ignored
// - moving to the internal mux stops primary oscillator and clears running flag
// - nonzero frequency select enables fast oscillator; stable flag after about 1 ms
// - stable flag already set stays set through mode entry
// - zero frequency select keeps fast oscillator off, flag clear, slow source clocks
// - internal idle wake starts core 10 us later, runs internal until primary ready
// - after switch back to primary, stable flag clears and running flag sets
// - slow oscillator runs whenever watchdog or fail-safe monitor is enabled
// - internal run clocks core and peripherals from mux, primary shut down
// - idle clear plus upper source bit gives internal run; lower bit ignored
// - frequency select writes change mux frequency at once, no sleep needed
// - entry and exit of internal run pay a switch delay only when the source changes
// - wake in internal run keeps mux clock while primary starts, then switches
// - each switch pauses clocks for eight ticks of the new source
// - two-bit source select picks primary, secondary or internal
module pm_clock_mode_ctrl #(
    parameter int STABLE_CYCLES = clk_mode_pkg::STABLE_CYCLES,
    parameter int WAKE_CYCLES = clk_mode_pkg::WAKE_CYCLES,
    parameter int FREQ_W = clk_mode_pkg::FREQ_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // core control bits and sleep trigger
    input wire logic sleep_exec_in,
    input wire logic idle_on_sleep_select_in,
    input wire logic [1:0] clock_source_select_in,
    input wire logic [FREQ_W-1:0] internal_freq_select_in,
    // events
    input wire logic wake_event_in,
    input wire logic watchdog_timeout_in,
    input wire logic watchdog_enable_in,
    input wire logic fail_safe_monitor_enable_in,
    // oscillator side
    input wire logic primary_clock_ready_in,
    input wire logic primary_tick_in,
    input wire logic secondary_tick_in,
    input wire logic internal_tick_in,
    // clock gates and oscillator enables
    output logic core_clk_en_out,
    output logic periph_clk_en_out,
    output logic primary_osc_en_out,
    output logic internal_fast_osc_en_out,
    output logic internal_slow_osc_en_out,
    output logic [FREQ_W-1:0] internal_freq_out,
    // status and reset request
    output logic watchdog_reset_out,
    output clk_mode_pkg::clk_status_t status_out
);

    // ********************************************************
    // local constants
    // ********************************************************
    localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
    localparam int STAB_W = $clog2(STABLE_CYCLES + 1);
    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
    localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STABLE_CYCLES - 1);
    localparam logic [3:0] SW_LAST = 4'(clk_mode_pkg::SWITCH_TICKS - 1);
    localparam logic [FREQ_W-1:0] FREQ_OFF = '0;

    // ********************************************************
    // decode helpers
    // ********************************************************
    // upper bit wins so the lower bit is a don't-care for the internal mux
    function automatic logic [1:0] decode_source(input logic [1:0] sel);
        decode_source = sel[1] ? clk_mode_pkg::SRC_INTERNAL :
                        (sel[0] ? clk_mode_pkg::SRC_SECONDARY : clk_mode_pkg::SRC_PRIMARY);
    endfunction : decode_source

    function automatic logic tick_of(input logic [1:0] src, input logic p, input logic s,
                                     input logic i);
        tick_of = (src == clk_mode_pkg::SRC_INTERNAL) ? i :
                  ((src == clk_mode_pkg::SRC_SECONDARY) ? s : p);
    endfunction : tick_of

    // ********************************************************
    // state
    // ********************************************************
    clk_mode_pkg::seq_state_t state_ff, nxt_state;
    logic [1:0] cur_src_ff, nxt_cur_src;
    logic [1:0] tgt_src_ff, nxt_tgt_src;
    logic idle_ff, nxt_idle;
    logic return_pending_ff, nxt_return_pending;
    logic [3:0] sw_cnt_ff, nxt_sw_cnt;
    logic [WAKE_W-1:0] wake_cnt_ff, nxt_wake_cnt;
    logic [STAB_W-1:0] stab_cnt_ff;
    logic fast_stable_ff;

    // ********************************************************
    // event decode
    // ********************************************************
    wire logic [1:0] sel_src = decode_source(clock_source_select_in);
    wire logic is_active = (state_ff == clk_mode_pkg::st_active);
    wire logic sleep_go = is_active && !idle_ff && sleep_exec_in;
    // a differing source always switches, even when primary is itself the internal block
    wire logic need_switch = (sel_src != cur_src_ff);
    wire logic idle_wake = is_active && idle_ff && (wake_event_in || watchdog_timeout_in);
    wire logic run_wdt_reset = is_active && !idle_ff && watchdog_timeout_in;
    wire logic run_wake = is_active && !idle_ff && wake_event_in
                          && (cur_src_ff != clk_mode_pkg::SRC_PRIMARY);
    wire logic back_go = is_active && !idle_ff && !sleep_exec_in && return_pending_ff
                         && primary_clock_ready_in;
    wire logic new_tick = tick_of(tgt_src_ff, primary_tick_in, secondary_tick_in,
                                  internal_tick_in);
    wire logic fast_en = (internal_freq_select_in != FREQ_OFF);

    // ********************************************************
    // sequencer next state
    // ********************************************************
    // the select bits are only read here, never written back
    always_comb begin
        nxt_state = state_ff;
        nxt_cur_src = cur_src_ff;
        nxt_tgt_src = tgt_src_ff;
        nxt_idle = idle_ff;
        nxt_return_pending = return_pending_ff;
        nxt_sw_cnt = sw_cnt_ff;
        nxt_wake_cnt = wake_cnt_ff;
        case (state_ff)
            clk_mode_pkg::st_active: begin
                if (sleep_go) begin
                    nxt_idle = idle_on_sleep_select_in;
                    nxt_return_pending = 1'b0;
                    if (need_switch) begin
                        nxt_tgt_src = sel_src;
                        nxt_sw_cnt = '0;
                        nxt_state = clk_mode_pkg::st_switch;
                    end
                end else if (idle_wake) begin
                    nxt_wake_cnt = '0;
                    nxt_state = clk_mode_pkg::st_wake_wait;
                end else if (run_wake) begin
                    nxt_return_pending = 1'b1;
                end else if (back_go) begin
                    nxt_tgt_src = clk_mode_pkg::SRC_PRIMARY;
                    nxt_return_pending = 1'b0;
                    nxt_sw_cnt = '0;
                    nxt_state = clk_mode_pkg::st_switch;
                end
            end
            clk_mode_pkg::st_switch: begin
                // the first tick lands anywhere in a period, so the pause is 7 to 8 periods
                if (new_tick) begin
                    if (sw_cnt_ff == SW_LAST) begin
                        nxt_cur_src = tgt_src_ff;
                        nxt_state = clk_mode_pkg::st_active;
                    end else begin
                        nxt_sw_cnt = sw_cnt_ff + 4'h1;
                    end
                end
            end
            clk_mode_pkg::st_wake_wait: begin
                if (wake_cnt_ff == WAKE_LAST) begin
                    nxt_idle = 1'b0;
                    nxt_return_pending = (cur_src_ff != clk_mode_pkg::SRC_PRIMARY);
                    nxt_state = clk_mode_pkg::st_active;
                end else begin
                    nxt_wake_cnt = wake_cnt_ff + WAKE_W'(1);
                end
            end
            default: begin
                nxt_state = clk_mode_pkg::st_active;
            end
        endcase
    end

    // ********************************************************
    // sequencer registers
    // ********************************************************
    // reset assumes the part comes up running from the primary clock
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_ff <= clk_mode_pkg::st_active;
            cur_src_ff <= clk_mode_pkg::SRC_PRIMARY;
            tgt_src_ff <= clk_mode_pkg::SRC_PRIMARY;
            idle_ff <= 1'b0;
            return_pending_ff <= 1'b0;
            sw_cnt_ff <= '0;
            wake_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cur_src_ff <= nxt_cur_src;
            tgt_src_ff <= nxt_tgt_src;
            idle_ff <= nxt_idle;
            return_pending_ff <= nxt_return_pending;
            sw_cnt_ff <= nxt_sw_cnt;
            wake_cnt_ff <= nxt_wake_cnt;
        end
    end

    // ********************************************************
    // fast oscillator stabilisation
    // ********************************************************
    // clocks keep running meanwhile; a nonzero-to-nonzero change keeps the flag
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || !fast_en) begin
            stab_cnt_ff <= '0;
            fast_stable_ff <= 1'b0;
        end else if (stab_cnt_ff == STAB_LAST) begin
            fast_stable_ff <= 1'b1;
        end else begin
            stab_cnt_ff <= stab_cnt_ff + STAB_W'(1);
        end
    end

    // ********************************************************
    // output gates and flags
    // ********************************************************
    wire logic nxt_switching = (nxt_state == clk_mode_pkg::st_switch);
    wire logic nxt_on_primary = (nxt_cur_src == clk_mode_pkg::SRC_PRIMARY);
    wire logic nxt_on_internal = (nxt_cur_src == clk_mode_pkg::SRC_INTERNAL);
    wire logic nxt_core_en = (nxt_state == clk_mode_pkg::st_active) && !nxt_idle;
    wire logic nxt_primary_en = nxt_on_primary || nxt_return_pending
                                || (nxt_switching && nxt_tgt_src == clk_mode_pkg::SRC_PRIMARY);
    wire logic nxt_slow_en = watchdog_enable_in || fail_safe_monitor_enable_in
                             || (nxt_on_internal && !fast_en);

    // outputs are registered from next state so they line up with the sequencer
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            core_clk_en_out <= 1'b1;
            periph_clk_en_out <= 1'b1;
            primary_osc_en_out <= 1'b1;
            internal_fast_osc_en_out <= 1'b0;
            internal_slow_osc_en_out <= 1'b0;
            internal_freq_out <= '0;
            watchdog_reset_out <= 1'b0;
            status_out <= '{source: clk_mode_pkg::SRC_PRIMARY, idle: 1'b0,
                            internal_osc_stable_flag: 1'b0, primary_clock_running_flag: 1'b1};
        end else begin
            core_clk_en_out <= nxt_core_en;
            periph_clk_en_out <= !nxt_switching;
            primary_osc_en_out <= nxt_primary_en;
            internal_fast_osc_en_out <= fast_en;
            internal_slow_osc_en_out <= nxt_slow_en;
            internal_freq_out <= internal_freq_select_in;
            watchdog_reset_out <= run_wdt_reset;
            status_out.source <= nxt_cur_src;
            status_out.idle <= nxt_idle;
            status_out.internal_osc_stable_flag <= fast_stable_ff && fast_en
                                                   && nxt_on_internal;
            status_out.primary_clock_running_flag <= nxt_on_primary
                                                     && !nxt_switching;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    property p_sleep_pick;
        sleep_go && !need_switch |=> idle_ff == $past(idle_on_sleep_select_in);
    endproperty
    a_sleep_pick: assert property (p_sleep_pick) else $error("idle not taken from sleep");

    property p_switch_start;
        sleep_go && need_switch |=> state_ff == clk_mode_pkg::st_switch
            && tgt_src_ff == $past(sel_src) && !periph_clk_en_out && !core_clk_en_out;
    endproperty
    a_switch_start: assert property (p_switch_start) else $error("switch not started");

    property p_wdt_split;
        (run_wdt_reset |=> watchdog_reset_out) and
        (is_active && idle_ff && watchdog_timeout_in
            |=> state_ff == clk_mode_pkg::st_wake_wait && !watchdog_reset_out);
    endproperty
    a_wdt_split: assert property (p_wdt_split) else $error("watchdog outcome wrong");

    property p_idle_gates;
        idle_ff && state_ff != clk_mode_pkg::st_switch |-> !core_clk_en_out && periph_clk_en_out;
    endproperty
    a_idle_gates: assert property (p_idle_gates) else $error("idle clock gating wrong");

    property p_wake_end;
        state_ff == clk_mode_pkg::st_wake_wait && wake_cnt_ff == WAKE_LAST
            |=> core_clk_en_out && cur_src_ff == $past(cur_src_ff) && is_active;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("core not resumed after delay");

    property p_wake_hold;
        state_ff == clk_mode_pkg::st_wake_wait && wake_cnt_ff != WAKE_LAST
            |=> state_ff == clk_mode_pkg::st_wake_wait && !core_clk_en_out;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("core woke too early");

    property p_switch_done;
        state_ff == clk_mode_pkg::st_switch && new_tick && sw_cnt_ff == SW_LAST
            |=> is_active && cur_src_ff == $past(tgt_src_ff) && periph_clk_en_out;
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch end wrong");

    property p_switch_wait;
        state_ff == clk_mode_pkg::st_switch && !new_tick |=> state_ff == clk_mode_pkg::st_switch;
    endproperty
    a_switch_wait: assert property (p_switch_wait) else $error("switch ended without tick");

    property p_primary_off;
        cur_src_ff == clk_mode_pkg::SRC_INTERNAL && is_active && !return_pending_ff
            |-> !primary_osc_en_out && !status_out.primary_clock_running_flag;
    endproperty
    a_primary_off: assert property (p_primary_off) else $error("primary still on");

    property p_freq_now;
        ##1 internal_freq_out == $past(internal_freq_select_in);
    endproperty
    a_freq_now: assert property (p_freq_now) else $error("frequency select lagging");

    property p_slow_on;
        watchdog_enable_in || fail_safe_monitor_enable_in |=> internal_slow_osc_en_out;
    endproperty
    a_slow_on: assert property (p_slow_on) else $error("slow oscillator stopped");

    property p_zero_freq;
        !fast_en |=> !internal_fast_osc_en_out && !status_out.internal_osc_stable_flag;
    endproperty
    a_zero_freq: assert property (p_zero_freq) else $error("fast oscillator on at zero");

    c_enter_internal_idle: cover property (sleep_go && idle_on_sleep_select_in
                                           && clock_source_select_in[1]);
    c_idle_wake: cover property (idle_wake ##1 state_ff == clk_mode_pkg::st_wake_wait);
    c_switch_back: cover property (back_go);
    c_wdt_reset: cover property (run_wdt_reset);

endmodule : pm_clock_mode_ctrl

// [inc/clk_mode_pkg.sv]
package clk_mode_pkg;

    // ********************************************************
    // clock source codes and timing
    // ********************************************************
    localparam logic [1:0] SRC_PRIMARY = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h2;
    localparam int FREQ_W = 3;
    localparam int CLK_MHZ = 250;
    localparam int WAKE_DELAY_US = 10;
    localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
    localparam int STABLE_TIME_MS = 1;
    localparam int STABLE_CYCLES = STABLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SWITCH_TICKS = 8;

    // ********************************************************
    // sequencer states and status carrier
    // ********************************************************
    typedef enum logic [1:0] {
        st_active,
        st_switch,
        st_wake_wait
    } seq_state_t;

    typedef struct packed {
        logic [1:0] source;
        logic idle;
        logic internal_osc_stable_flag;
        logic primary_clock_running_flag;
    } clk_status_t;

endpackage : clk_mode_pkg

// [tb/osc_partner.sv]
`timescale 1ns/1ps
// ********************************************************
// oscillator side: source ticks and primary ready
// ********************************************************
module osc_partner (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // primary oscillator enable from the controller
    input wire logic primary_osc_en_in,
    // source ticks and primary ready
    output logic primary_tick_out,
    output logic secondary_tick_out,
    output logic internal_tick_out,
    output logic primary_ready_out
);
    int div_cnt;
    int start_cnt;
    int start_lim;
    // a stopped primary oscillator gives no ticks and loses ready at once
    always @(posedge clk_in) begin
        div_cnt <= reset_in ? 0 : div_cnt + 1;
        start_cnt <= primary_osc_en_in ? start_cnt + 1 : 0;
        if (!primary_osc_en_in) begin
            start_lim <= 2 + ($urandom % 40); // start-up time varies, prompt or slow
        end
    end
    assign primary_tick_out = primary_osc_en_in && (div_cnt % 3 == 0);
    assign secondary_tick_out = (div_cnt % 5 == 0);
    assign internal_tick_out = (div_cnt % 4 == 0);
    assign primary_ready_out = primary_osc_en_in && (start_cnt > start_lim);
endmodule : osc_partner

// [tb/test_power_managed_clock_mode_control.sv]
`timescale 1ns/1ps
module test_power_managed_clock_mode_control;
    // ********************************************************
    // signals and model state
    // ********************************************************
    localparam int STAB = 200;
    localparam int WAKE = 10;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sleep_exec_in = 1'b0;
    logic idle_sel = 1'b0;
    logic [1:0] src_sel = 2'h0;
    logic [clk_mode_pkg::FREQ_W-1:0] freq_sel = '0;
    logic wake_in = 1'b0;
    logic wdt_to = 1'b0;
    logic wdt_en = 1'b0;
    logic fsm_en = 1'b0;
    logic p_tick, s_tick, i_tick, p_ready;
    logic core_en, periph_en, posc_en, fast_en, slow_en, wdt_rst;
    logic [clk_mode_pkg::FREQ_W-1:0] freq_out;
    clk_mode_pkg::clk_status_t status;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int stab_cnt = 0;
    int k;
    logic [1:0] exp_src = 2'h0;
    logic exp_idle = 1'b0;

    pm_clock_mode_ctrl #(.STABLE_CYCLES(STAB), .WAKE_CYCLES(WAKE)) dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .sleep_exec_in(sleep_exec_in),
        .idle_on_sleep_select_in(idle_sel), .clock_source_select_in(src_sel),
        .internal_freq_select_in(freq_sel), .wake_event_in(wake_in),
        .watchdog_timeout_in(wdt_to), .watchdog_enable_in(wdt_en),
        .fail_safe_monitor_enable_in(fsm_en), .primary_clock_ready_in(p_ready),
        .primary_tick_in(p_tick), .secondary_tick_in(s_tick), .internal_tick_in(i_tick),
        .core_clk_en_out(core_en), .periph_clk_en_out(periph_en),
        .primary_osc_en_out(posc_en), .internal_fast_osc_en_out(fast_en),
        .internal_slow_osc_en_out(slow_en), .internal_freq_out(freq_out),
        .watchdog_reset_out(wdt_rst), .status_out(status));

    osc_partner osc (
        .clk_in(sys_clk_in), .reset_in(reset_in), .primary_osc_en_in(posc_en),
        .primary_tick_out(p_tick), .secondary_tick_out(s_tick),
        .internal_tick_out(i_tick), .primary_ready_out(p_ready));

    // clock, cycle limit and the model's view of oscillator settling
    initial forever #2 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        stab_cnt <= (freq_sel == 0) ? 0 : stab_cnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ********************************************************
    // compare and sequence tasks
    // ********************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // stable flag only counts once the model has seen the settle time pass
    task automatic chk_status();
        logic stab;
        stab = (exp_src == 2'h2) && (stab_cnt > STAB + 3);
        chk(status, {exp_src, exp_idle, stab, exp_src == 2'h0});
    endtask : chk_status

    task automatic wait_periph(input int per);
        k = 0;
        while (periph_en !== 1'b1 && k < 9 * per + 4) begin
            @(negedge sys_clk_in);
            k++;
        end
        chk(k >= 7 * per && k <= 8 * per + 1, 1);
    endtask : wait_periph

    task automatic do_sleep(input logic idl, input logic [1:0] clock_source_select);
        logic [1:0] tgt;
        tgt = clock_source_select[1] ? 2'h2 : clock_source_select;
        idle_sel = idl;
        src_sel = clock_source_select;
        sleep_exec_in = 1'b1;
        @(negedge sys_clk_in);
        sleep_exec_in = 1'b0;
        if (tgt != exp_src) begin
            chk({core_en, periph_en}, 2'h0);
            wait_periph(tgt == 2'h2 ? 4 : (tgt == 2'h1 ? 5 : 3));
        end
        exp_src = tgt;
        exp_idle = idl;
        chk({core_en, periph_en}, {~idl, 1'b1});
        chk_status();
        if (tgt == 2'h2) chk(posc_en, 0);
    endtask : do_sleep

    task automatic do_wake(input logic by_wdt);
        logic bad;
        bad = 1'b0;
        repeat ($urandom % 5) @(negedge sys_clk_in);
        {wdt_to, wake_in} = by_wdt ? 2'h2 : 2'h1;
        @(negedge sys_clk_in);
        {wdt_to, wake_in} = 2'h0;
        chk(wdt_rst, 0);
        if (exp_idle) begin
            k = 0;
            while (core_en !== 1'b1 && k < WAKE + 5) begin
                bad |= (periph_en !== 1'b1);
                @(negedge sys_clk_in);
                k++;
            end
            chk(k, WAKE);
            chk(bad, 0);
            exp_idle = 1'b0;
        end
        chk_status();
        if (exp_src != 2'h0) begin
            k = 0;
            while (periph_en === 1'b1 && k < 300) begin
                bad |= (core_en !== 1'b1);
                @(negedge sys_clk_in);
                k++;
            end
            chk({bad, core_en}, 2'h0);
            wait_periph(3);
            exp_src = 2'h0;
            chk(core_en, 1);
            chk_status();
        end
    endtask : do_wake

    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        void'($urandom(32'h5DDCEAB3));
        repeat (10) @(negedge sys_clk_in);
        reset_in = 1'b0;
        chk({core_en, periph_en, posc_en, fast_en, freq_out}, 8'h70);
        chk_status();
        // slow oscillator kept alive by either enable
        for (int i = 0; i < 4; i++) begin
            {fsm_en, wdt_en} = i[1:0];
            repeat (2) @(negedge sys_clk_in);
            chk(slow_en, i != 0);
        end
        // enables off, so later slow oscillator checks see the zero-frequency path alone
        {fsm_en, wdt_en} = 2'h0;
        // primary idle then wake: no switch for an unchanged source
        do_sleep(1'b1, 2'h0);
        do_wake(1'b0);
        // internal idle with zero frequency, then settle a nonzero one
        do_sleep(1'b1, 2'h3);
        chk({fast_en, slow_en}, 2'h1);
        freq_sel = 3'(1 + $urandom % 7);
        k = 0;
        while (status.internal_osc_stable_flag !== 1'b1 && k < STAB + 9) begin
            @(negedge sys_clk_in);
            k++;
            if (k == 1) chk({fast_en, slow_en, freq_out},
                            {2'b10, freq_sel});
            if (periph_en !== 1'b1) chk(periph_en, 1);
        end
        chk(k >= STAB + 1 && k <= STAB + 3, 1);
        do_wake(1'b1);
        // internal run, entered with an already settled oscillator
        freq_sel = '0;
        @(negedge sys_clk_in);
        freq_sel = 3'(1 + $urandom % 7);
        repeat (STAB + 6) @(negedge sys_clk_in);
        do_sleep(1'b0, 2'h2);
        wdt_to = 1'b1;
        @(negedge sys_clk_in);
        wdt_to = 1'b0;
        chk({wdt_rst, core_en}, 2'h3);
        @(negedge sys_clk_in);
        chk(wdt_rst, 0);
        chk_status();
        freq_sel = '0;
        repeat (2) @(negedge sys_clk_in);
        chk({fast_en, slow_en, freq_out}, 5'h08);
        chk_status();
        do_wake(1'b0);
        // secondary run, then idle on the same source
        do_sleep(1'b0, 2'h1);
        do_sleep(1'b1, 2'h1);
        do_wake(1'b0);
        // reset in mid-run from internal idle must bring back primary run at once
        do_sleep(1'b1, 2'h2);
        reset_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        reset_in = 1'b0;
        exp_src = 2'h0;
        exp_idle = 1'b0;
        chk({core_en, periph_en, posc_en, fast_en, freq_out}, 8'h70);
        chk_status();
        do_sleep(1'b1, 2'h0);
        do_wake(1'b0);
        tally_and_finish();
    end
endmodule : test_power_managed_clock_mode_control
